// ---- include/sftc_defs.vh ----
// Constants for the soft timer channel: units, modes, directions, states, trigger.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef SFTC_DEFS_VH
`define SFTC_DEFS_VH
`define SFTC_CLK_MHZ 125
`define SFTC_US_NS 1000
`define SFTC_CLK_NS 8
`define SFTC_US_CYCLES (`SFTC_US_NS / `SFTC_CLK_NS)
`define SFTC_MS_PER_US 1000
`define SFTC_S_PER_MS 1000
`define SFTC_UNIT_SEC 2'h0
`define SFTC_UNIT_MS 2'h1
`define SFTC_UNIT_US 2'h2
`define SFTC_UNIT_RST 2'h1
`define SFTC_MODE_FREE 1'b0
`define SFTC_MODE_TOGGLE 1'b1
`define SFTC_DIR_UP 1'b0
`define SFTC_DIR_DOWN 1'b1
`define SFTC_REPC_MAX 30'h3B9A_CA00
`define SFTC_ST_STOP 3'h0
`define SFTC_ST_FREE 3'h1
`define SFTC_ST_DELAY 3'h2
`define SFTC_ST_INTV 3'h3
`define SFTC_TRIG_NONE 4'h8
`endif

// ---- hdl/sftc_timer.v ----
// Soft timer channel: free counter and toggle output on one pin.
// Assumes commands are one-cycle pulses from core_clk logic; the pin input
// and the trigger starts of other channels come from outside and are synchronised.
//
// Summary of operation
// - Free counter up or down, default up
// - Up count always starts from zero
// - Down count starts at loaded value
// - Count read gives present value
// - Seconds, milliseconds, microseconds time units
// - Toggle mode inverts pin at time points
// - Open-drain/push-pull, force level, invert
// - Output settings act immediately
// - Optional delay before first toggle
// - Repeat zero means one billion
// - One to eight stored intervals
// - Intervals used in order, then wrap
// - Optional start from channel zero..seven
// - Default: software start only
// - Repeat read gives remaining repeats
// - Stop halts at once, pin holds
// - Reset command restores reset condition
// - Reset unit is milliseconds
`timescale 1ns/1ps
`include "sftc_defs.vh"
module sftc_timer #(
  parameter CNT_W = 64,
  parameter TIME_W = 32,
  parameter REPC_W = 30,
  parameter NSLOT = 8,
  parameter CHANS = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_reset,
  input wire cfg_mode,
  input wire [1:0] cfg_unit,
  input wire cfg_dir,
  input wire [CNT_W-1:0] cfg_start_count,
  input wire [TIME_W-1:0] cfg_delay,
  input wire [REPC_W-1:0] cfg_repc,
  input wire [3:0] cfg_trig_src,
  input wire cfg_open_drain,
  input wire cfg_force_we,
  input wire cfg_force_level,
  input wire cfg_invert,
  input wire intv_we,
  input wire [2:0] intv_addr,
  input wire [TIME_W-1:0] intv_data,
  input wire [3:0] intv_count,
  input wire [CHANS-1:0] chan_start_in,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg [CNT_W-1:0] count_value,
  output reg [REPC_W-1:0] repc_left,
  output reg [2:0] state_code,
  output reg started
);
  // One-hot run states
  localparam S_STOP = 4'b0001;
  localparam S_FREE = 4'b0010;
  localparam S_DELAY = 4'b0100;
  localparam S_INTV = 4'b1000;
  // Slot limit at the width of the slot-count register
  localparam [3:0] NSLOT_CAP = NSLOT[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for foreign inputs
  reg [CHANS-1:0] trig_s1;
  reg [CHANS-1:0] trig_s2;
  reg [CHANS-1:0] trig_s3;
  reg pin_s1;
  reg pin_s2;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      trig_s1 <= {CHANS{1'b0}};
      trig_s2 <= {CHANS{1'b0}};
      trig_s3 <= {CHANS{1'b0}};
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      trig_s1 <= chan_start_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end
  wire [CHANS-1:0] trig_rise = trig_s2 & ~trig_s3;
  // Source 8 and above means no trigger; the channel waits for software
  wire trig_hit = (cfg_trig_src < `SFTC_TRIG_NONE) && trig_rise[cfg_trig_src[2:0]];

  ////////////////////////////////////////////////////////////////////////
  // Time base: 1 us tick, then ms and s by divide-by-1000 dividers
  reg [1:0] unit;
  reg [6:0] us_div;
  reg [9:0] ms_div;
  reg [9:0] s_div;
  wire us_tick = (us_div == `SFTC_US_CYCLES - 1);
  wire ms_tick = us_tick && (ms_div == `SFTC_MS_PER_US - 1);
  wire s_tick = ms_tick && (s_div == `SFTC_S_PER_MS - 1);
  reg unit_tick;
  always @* begin
    case (unit)
      `SFTC_UNIT_SEC: unit_tick = s_tick;
      `SFTC_UNIT_US: unit_tick = us_tick;
      default: unit_tick = ms_tick;
    endcase
  end

  reg [3:0] state;
  reg [TIME_W-1:0] intv_mem [0:NSLOT-1];
  reg [TIME_W-1:0] tcnt;
  reg [2:0] slot;
  reg [3:0] nslot;
  reg dir;
  reg level;
  reg ignore_count;

  wire [2:0] last_slot = (nslot == 4'h0) ? 3'h0 : nslot[2:0] - 3'h1;
  wire [2:0] next_slot = (slot == last_slot) ? 3'h0 : slot + 3'h1;
  wire go = (cmd_start || trig_hit) && !cmd_stop;

  always @(posedge core_clk) begin
    if (intv_we) begin
      intv_mem[intv_addr] <= intv_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main state machine
  always @(posedge core_clk) begin
    if (sys_rst || cmd_reset) begin
      state <= S_STOP;
      unit <= `SFTC_UNIT_RST;
      us_div <= 7'h00;
      ms_div <= 10'h000;
      s_div <= 10'h000;
      count_value <= {CNT_W{1'b0}};
      repc_left <= {REPC_W{1'b0}};
      tcnt <= {TIME_W{1'b0}};
      slot <= 3'h0;
      nslot <= 4'h1;
      dir <= `SFTC_DIR_UP;
      level <= 1'b0;
      started <= 1'b0;
      ignore_count <= 1'b0;
    end else begin
      started <= 1'b0;
      unit <= cfg_unit;
      us_div <= us_tick ? 7'h00 : us_div + 7'h01;
      if (us_tick) begin
        ms_div <= (ms_div == `SFTC_MS_PER_US - 1) ? 10'h000 : ms_div + 10'h001;
      end
      if (ms_tick) begin
        s_div <= (s_div == `SFTC_S_PER_MS - 1) ? 10'h000 : s_div + 10'h001;
      end
      if (cfg_force_we) begin
        level <= cfg_force_level;
      end
      ignore_count <= pin_s2 & 1'b0;
      case (state)
        S_STOP: begin
          if (go) begin
            started <= 1'b1;
            // Prescaler restarts so the first step is a whole unit
            us_div <= 7'h00;
            ms_div <= 10'h000;
            s_div <= 10'h000;
            if (cfg_mode == `SFTC_MODE_FREE) begin
              dir <= cfg_dir;
              count_value <= (cfg_dir == `SFTC_DIR_DOWN) ? cfg_start_count : {CNT_W{1'b0}};
              state <= S_FREE;
            end else begin
              nslot <= (intv_count == 4'h0) ? 4'h1 : ((intv_count > NSLOT_CAP) ? NSLOT_CAP : intv_count);
              slot <= 3'h0;
              repc_left <= (cfg_repc == {REPC_W{1'b0}}) ? `SFTC_REPC_MAX : cfg_repc;
              tcnt <= cfg_delay;
              state <= S_DELAY;
            end
          end
        end
        S_FREE: begin
          if (cmd_stop) begin
            state <= S_STOP;
          end else if (unit_tick) begin
            if (dir == `SFTC_DIR_UP) begin
              count_value <= count_value + {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (count_value != {CNT_W{1'b0}}) begin
              count_value <= count_value - {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
        S_DELAY: begin
          if (cmd_stop) begin
            state <= S_STOP;
          end else if (tcnt == {TIME_W{1'b0}}) begin
            tcnt <= intv_mem[3'h0];
            state <= S_INTV;
          end else if (unit_tick) begin
            tcnt <= tcnt - {{(TIME_W-1){1'b0}}, 1'b1};
          end
        end
        S_INTV: begin
          if (cmd_stop) begin
            state <= S_STOP;
          end else if (unit_tick) begin
            if (tcnt <= {{(TIME_W-1){1'b0}}, 1'b1}) begin
              level <= ~level;
              repc_left <= repc_left - {{(REPC_W-1){1'b0}}, 1'b1};
              slot <= next_slot;
              tcnt <= intv_mem[next_slot];
              if (repc_left == {{(REPC_W-1){1'b0}}, 1'b1}) begin
                state <= S_STOP;
              end
            end else begin
              tcnt <= tcnt - {{(TIME_W-1){1'b0}}, 1'b1};
            end
          end
        end
        default: state <= S_STOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive and status, all registered
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      state_code <= `SFTC_ST_STOP;
    end else begin
      // Open drain only drives low; high is left to the pull-up
      pin_out <= (level ^ cfg_invert) & ~cfg_open_drain;
      pin_oe <= cfg_open_drain ? ~(level ^ cfg_invert) : 1'b1;
      case (state)
        S_FREE: state_code <= `SFTC_ST_FREE;
        S_DELAY: state_code <= `SFTC_ST_DELAY;
        S_INTV: state_code <= `SFTC_ST_INTV;
        default: state_code <= `SFTC_ST_STOP;
      endcase
    end
  end
endmodule

// ---- test/sftc_checker.sv ----
// Port checker for the soft timer channel, bound to every sftc_timer.
// Assumes one-cycle command pulses and settings held steady around a start.
`timescale 1ns/1ps
`include "sftc_defs.vh"
module sftc_checker #(
  parameter CNT_W = 64,
  parameter REPC_W = 30
) (
  input wire core_clk,
  input wire sys_rst,
  input wire cmd_start,
  input wire cmd_stop,
  input wire cmd_reset,
  input wire cfg_mode,
  input wire cfg_dir,
  input wire [CNT_W-1:0] cfg_start_count,
  input wire [REPC_W-1:0] cfg_repc,
  input wire cfg_open_drain,
  input wire cfg_force_we,
  input wire cfg_force_level,
  input wire cfg_invert,
  input wire pin_out,
  input wire pin_oe,
  input wire [CNT_W-1:0] count_value,
  input wire [REPC_W-1:0] repc_left,
  input wire [2:0] state_code,
  input wire started
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // The started guard skips the cycle where a run is accepted but not yet shown
  a_start_answer: assert property (cmd_start && !cmd_stop && !cmd_reset && state_code == 3'h0 && !started |=> started)
    else $error("start not taken");
  a_up_zero: assert property (started && !$past(cfg_mode) && !$past(cfg_dir) |-> count_value == 0)
    else $error("up count not from zero");
  a_down_load: assert property (started && !$past(cfg_mode) && $past(cfg_dir) |-> count_value == $past(cfg_start_count))
    else $error("down count not loaded");
  a_free_step: assert property (state_code == 3'h1 && $past(state_code) == 3'h1
    && !$past(cmd_reset) && $changed(count_value)
    |-> count_value - $past(count_value) == 1 || $past(count_value) - count_value == 1) else $error("count step");
  a_repc_zero: assert property (started && $past(cfg_mode) && $past(cfg_repc) == 0 |-> ##[0:1] repc_left == `SFTC_REPC_MAX)
    else $error("repeat zero");
  a_last_stop: assert property ($past(repc_left) == 1 && repc_left == 0 |-> ##[0:2] state_code == 3'h0)
    else $error("no stop after repeats");
  a_stop_pin: assert property (cmd_stop && state_code == `SFTC_ST_INTV |-> ##2 $stable(pin_out) [*6])
    else $error("pin moved after stop");
  // Counts clear one cycle after the command, the state code one cycle later
  a_reset_cmd: assert property (cmd_reset |-> ##1 (count_value == 0 && repc_left == 0) ##1 state_code == 3'h0)
    else $error("reset command");
  // Judged on the line level: a released open-drain output reads high
  a_force_now: assert property (cfg_force_we && state_code == 3'h0 |-> ##2
    (pin_oe ? pin_out : 1'b1) == ($past(cfg_force_level, 2) ^ $past(cfg_invert)))
    else $error("force late");
  a_od_release: assert property (cfg_open_drain [*2] ##1 (cfg_open_drain && pin_oe) |-> !pin_out)
    else $error("open drain drives high");
  c_start: cover property (started);
  c_done: cover property (repc_left == 1 ##1 repc_left == 0);
  c_stop_run: cover property (cmd_stop && state_code == `SFTC_ST_INTV);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sftc_timer sftc_checker #(.CNT_W(CNT_W), .REPC_W(REPC_W)) chk (.*);

// ---- test/sftc_pin_model.sv ----
// Port pin on the far side of the channel.
// Assumes a pull-up, so a released line reads high.
`timescale 1ns/1ps
module sftc_pin_model (
  input wire pin_out,
  input wire pin_oe,
  output wire pin_line
);
  assign pin_line = pin_oe ? pin_out : 1'b1;
endmodule

// ---- test/tb.sv ----
// Bench for the soft timer channel: free count, toggle, output, trigger.
// Runs in microseconds so that one unit is a short, exact cycle count.
`timescale 1ns/1ps
`include "sftc_defs.vh"
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
  localparam int U = `SFTC_US_CYCLES;
  logic core_clk = 0, sys_rst = 1, cmd_start = 0, cmd_stop = 0, cmd_reset = 0, cfg_mode = 0, cfg_dir = 0;
  logic cfg_open_drain = 0, cfg_force_we = 0, cfg_force_level = 0, cfg_invert = 0, intv_we = 0;
  logic [1:0] cfg_unit = `SFTC_UNIT_US;
  logic [63:0] cfg_start_count = 0;
  logic [31:0] cfg_delay = 32'h1, intv_data = 0;
  logic [29:0] cfg_repc = 30'h4;
  logic [3:0] cfg_trig_src = `SFTC_TRIG_NONE, intv_count = 4'h3;
  logic [2:0] intv_addr = 0;
  logic [7:0] chan_start_in = 0;
  wire pin_in, pin_out, pin_oe, started;
  wire [63:0] count_value;
  wire [29:0] repc_left;
  wire [2:0] state_code;
  int miscompares = 0, checks_done = 0;
  sftc_timer uut (.*);
  sftc_pin_model pin (.pin_out(pin_out), .pin_oe(pin_oe), .pin_line(pin_in));
  always #4 core_clk = ~core_clk;
  task cy(input int n); repeat (n) @(posedge core_clk); endtask
  task cmd(input logic [2:0] c);
    cy(1); {cmd_reset, cmd_stop, cmd_start} <= c; cy(1); {cmd_reset, cmd_stop, cmd_start} <= 3'h0;
  endtask
  task set_lvl(input logic l);
    cy(1); cfg_force_level <= l; cfg_force_we <= 1'b1; cy(1); cfg_force_we <= 1'b0;
  endtask
  task t_out;
    set_lvl(1'b1); cy(2); #1 `CK(pin_out, 1'b1)
    cy(1); cfg_invert <= 1'b1; cy(2); #1 `CK(pin_out, 1'b0)
    cy(1); cfg_invert <= 1'b0; cfg_open_drain <= 1'b1; cy(2); #1 `CK(pin_in, 1'b1)
    `CK(pin_oe, 1'b0)
    set_lvl(1'b0); cy(2); #1 `CK(pin_in, 1'b0)
    cy(1); cfg_open_drain <= 1'b0;
  endtask
  task t_up;
    cy(1); cfg_start_count <= 64'h9;
    cmd(3'h1); #1 `CK(started, 1'b1)
    cy(1); #1 `CK(count_value, 64'h0)
    cy(3 * U + U / 2); #1 `CK(count_value, 64'h3)
    `CK(state_code, `SFTC_ST_FREE)
    cmd(3'h2); cy(2); #1 `CK(state_code, 3'h0)
  endtask
  task t_down;
    cy(1); cfg_dir <= 1'b1; cfg_start_count <= 64'h2;
    cmd(3'h1); cy(1); #1 `CK(count_value, 64'h2)
    cy(4 * U); #1 `CK(count_value, 64'h0)
    cmd(3'h4); cy(2); #1 `CK(state_code, 3'h0)
  endtask
  task t_trig;
    cy(1); cfg_dir <= 1'b0; chan_start_in <= 8'h08; cy(8); #1 `CK(state_code, 3'h0)
    cy(1); chan_start_in <= 8'h00; cfg_trig_src <= 4'h3; cfg_unit <= `SFTC_UNIT_MS; cy(2); chan_start_in <= 8'h08;
    cy(8); #1 `CK(state_code, `SFTC_ST_FREE)
    // Millisecond unit: three microseconds must not move the count
    cy(3 * U); #1 `CK(count_value, 64'h0)
    cmd(3'h4); cy(2); #1 `CK(state_code, 3'h0)
    cy(1); cfg_unit <= `SFTC_UNIT_US;
  endtask
  task t_tog;
    int i, n, t[4];
    logic p;
    logic [29:0] r;
    for (i = 0; i < 3; i++) begin
      cy(1); intv_addr <= i[2:0]; intv_data <= 32'h0000_000A + i; intv_we <= 1'b1;
    end
    cy(1); intv_we <= 1'b0; cfg_mode <= 1'b1;
    cmd(3'h1); p = pin_out; n = 0;
    for (i = 1; i < 50 * U; i++) begin
      cy(1); #1;
      if (pin_out !== p && n < 4) begin
        t[n] = i; n++; if (n == 1) r = repc_left;
      end
      p = pin_out;
    end
    `CK(n, 4)
    `CK(t[0] >= 11 * U && t[0] < 11 * U + 8, 1'b1)
    `CK(t[1] - t[0], 11 * U)
    `CK(t[2] - t[1], 12 * U)
    `CK(t[3] - t[2], 10 * U)
    `CK(r, 30'h3)
    `CK(state_code, 3'h0)
  endtask
  task t_rep0;
    logic p;
    cy(1); cfg_repc <= 30'h0;
    cmd(3'h1); cy(2); #1 `CK(repc_left, `SFTC_REPC_MAX)
    cy(12 * U); cmd(3'h2); #1 p = pin_out; cy(12 * U); #1 `CK(pin_out, p)
    `CK(state_code, 3'h0)
  endtask
  task conclude;
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cy(8); sys_rst <= 1'b0; cy(1); #1 `CK(state_code, 3'h0)
    `CK(pin_oe, 1'b1)
    t_out; t_up; t_down; t_trig; t_tog; t_rep0;
    conclude;
  end
  // Whole run is near 85 us; the margin covers a design that never stops
  initial begin
    #200_000; miscompares++; conclude;
  end
endmodule
